// ### design/apc_pkg.sv
// constants for the playback protection configuration bank
package apc_pkg;
   // register addresses on the control port
   localparam logic [7:0] REG_LIM_ADDR = 8'h2b;
   localparam logic [7:0] REG_MIX_ADDR = 8'h2c;
   localparam logic [7:0] REG_PROT_ADDR = 8'h2d;
   // reset values
   localparam logic [7:0] REG_LIM_RST = 8'h00;
   localparam logic [7:0] REG_MIX_RST = 8'h00;
   localparam logic [7:0] REG_PROT_RST = 8'h00;
   // writable bits, reserved bits stay zero
   localparam logic [7:0] LIM_WMASK = 8'hfc;
   localparam logic [7:0] MIX_WMASK = 8'hf0;
   localparam logic [7:0] PROT_WMASK = 8'hff;
   localparam logic [7:0] RDATA_NONE = 8'h00;
   // power limiter fields
   localparam int unsigned LIM_ON_BIT = 7;
   localparam int unsigned LIM_ATTN_MSB = 6;
   localparam int unsigned LIM_ATTN_LSB = 4;
   localparam int unsigned LIM_SRC_BIT = 3;
   localparam int unsigned LIM_RECOV_BIT = 2;
   // mixer fields
   localparam int unsigned MIX_SERIAL_BIT = 7;
   localparam int unsigned MIX_SIDE_BIT = 6;
   localparam int unsigned MIX_ADC_BIT = 5;
   localparam int unsigned MIX_LOOP_BIT = 4;
   // protection fields
   localparam int unsigned PROT_DIST_BIT = 7;
   localparam int unsigned PROT_DROOP_BIT = 6;
   localparam int unsigned PROT_THERM_BIT = 5;
   localparam int unsigned PROT_COMP_BIT = 4;
   localparam int unsigned PROT_GEN1_BIT = 3;
   localparam int unsigned PROT_GEN2_BIT = 2;
   localparam int unsigned PROT_SUPPLY_BIT = 1;
   localparam int unsigned PROT_BROWN_BIT = 0;
   // attenuation
   localparam int unsigned ATTN_W = 3;
   localparam logic [2:0] ATTN_NONE = 3'h0;
   localparam logic [5:0] ATTN_STEP_DB = 6'h06;
endpackage

// ### design/apc_pin_sync.sv
// three-stage synchroniser for a pin input with agreement filter
`timescale 1ns/1ps
`default_nettype none
module apc_pin_sync (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // pin and synchronised level
   input wire logic pin_i,
   output logic level_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // level follows only once the second and third stages agree
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
      end else if (s2_r == s3_r) begin
         level_o <= s3_r;
      end
   end
endmodule
`default_nettype wire

// ### design/apc_sample_shadow.sv
// shadow copy of a register, reloaded only at a sample boundary
`timescale 1ns/1ps
`default_nettype none
module apc_sample_shadow #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // live value and boundary strobe
   input wire logic tick_i,
   input wire logic [7:0] live_i,
   // value seen by the processing path
   output logic [7:0] shadow_o
);
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shadow_o <= RST_VAL;
      end else if (tick_i) begin
         shadow_o <= live_i;
      end
   end
endmodule
`default_nettype wire

// ### design/apc_prot_cfg.sv
// playback protection and mixer configuration bank with power limiter tracking
// Functional notes
// - power limiter bit 7 turns the limiter on when set, off when clear
// - bits 6-4 pick limiter attenuation in 6 dB steps, 0 to -42 dB
// - bit 3 picks attenuation from pin and field, or from analog lookup
// - recovery bit clear: with limiter on, applied attenuation never decreases, only holds or rises
// - recovery bit set: attenuation may drop when pin low or supply recovered
// - mixer register at 0x2c bit 7 enables the playback serial mixer
// - mixer bit 6 enables the side-chain mixer
// - mixer bit 5 enables the ADC channel mixer
// - mixer bit 4 enables loopback mixer; bits 3-0 read zero
// - protection register at 0x2d bit 7 enables the distortion limiter
// - protection bit 6 enables supply droop protection
// - protection bit 5 enables thermal foldback
// - protection bit 4 enables the dynamic range compressor
// - protection bit 3 enables the first signal generator
// - protection bit 2 enables the second signal generator
// - protection bit 1 picks battery or analog supply measurement
// - protection bit 0 enables brownout shutdown
// - mixer and protection registers reset to 0x00, all features off
// - power limiter register sits at 0x2b and resets to 0x00
`timescale 1ns/1ps
`default_nettype none
module apc_prot_cfg
   import apc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // control port register access
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // processing path timing and inputs
   input wire logic sample_tick_i,
   input wire logic limit_pin_i,
   input wire logic [2:0] gpa_atten_code_i,
   input wire logic gpa_recovered_i,
   // power limiter result
   output logic applied_atten_on_o,
   output logic [2:0] applied_atten_code_o,
   output logic [5:0] applied_atten_db_o,
   // mixer enables
   output logic playback_serial_mixer_on_o,
   output logic side_chain_mixer_on_o,
   output logic adc_channel_mixer_on_o,
   output logic loopback_mixer_on_o,
   // protection enables
   output logic distortion_limiter_on_o,
   output logic droop_protection_on_o,
   output logic thermal_foldback_on_o,
   output logic compressor_on_o,
   output logic sig_gen1_on_o,
   output logic sig_gen2_on_o,
   output logic supply_measure_source_o,
   output logic brownout_shutdown_on_o
);
   logic [7:0] lim_r;
   logic [7:0] mix_r;
   logic [7:0] prot_r;
   logic [7:0] lim_sh;
   logic [7:0] mix_sh;
   logic [7:0] prot_sh;
   logic [7:0] rdata_nxt;
   logic pin_level;
   logic tick_d_r;
   logic power_limiter_on;
   logic [2:0] limiter_attenuation_code;
   logic attenuation_source_select;
   logic attenuation_recovery_allow;
   logic [2:0] target_code;
   logic recover_ok;
   logic [2:0] applied_nxt;

   // pin from outside the clock domain
   apc_pin_sync u_pin_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .pin_i(limit_pin_i),
      .level_o(pin_level)
   );

   // live register writes, reserved bits forced to zero
   // reserved bits masked
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lim_r <= REG_LIM_RST;
         mix_r <= REG_MIX_RST;
         prot_r <= REG_PROT_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == REG_LIM_ADDR) begin
            lim_r <= reg_wdata_i & LIM_WMASK;
         end
         if (reg_addr_i == REG_MIX_ADDR) begin
            mix_r <= reg_wdata_i & MIX_WMASK;
         end
         if (reg_addr_i == REG_PROT_ADDR) begin
            prot_r <= reg_wdata_i & PROT_WMASK;
         end
      end
   end

   // read mux, unmapped addresses return zero
   // reserved mixer bits read zero
   always_comb begin
      case (reg_addr_i)
         REG_LIM_ADDR: rdata_nxt = lim_r;
         REG_MIX_ADDR: rdata_nxt = mix_r;
         REG_PROT_ADDR: rdata_nxt = prot_r;
         default: rdata_nxt = RDATA_NONE;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= RDATA_NONE;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_nxt;
      end
   end

   apc_sample_shadow #(
      .RST_VAL(REG_LIM_RST)
   ) u_lim_sh (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .tick_i(sample_tick_i),
      .live_i(lim_r),
      .shadow_o(lim_sh)
   );

   apc_sample_shadow #(
      .RST_VAL(REG_MIX_RST)
   ) u_mix_sh (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .tick_i(sample_tick_i),
      .live_i(mix_r),
      .shadow_o(mix_sh)
   );

   apc_sample_shadow #(
      .RST_VAL(REG_PROT_RST)
   ) u_prot_sh (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .tick_i(sample_tick_i),
      .live_i(prot_r),
      .shadow_o(prot_sh)
   );

   // mixer and protection enables from the shadows
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         playback_serial_mixer_on_o <= 1'b0;
         side_chain_mixer_on_o <= 1'b0;
         adc_channel_mixer_on_o <= 1'b0;
         loopback_mixer_on_o <= 1'b0;
         distortion_limiter_on_o <= 1'b0;
         droop_protection_on_o <= 1'b0;
         thermal_foldback_on_o <= 1'b0;
         compressor_on_o <= 1'b0;
         sig_gen1_on_o <= 1'b0;
         sig_gen2_on_o <= 1'b0;
         supply_measure_source_o <= 1'b0;
         brownout_shutdown_on_o <= 1'b0;
      end else begin
         playback_serial_mixer_on_o <= mix_sh[MIX_SERIAL_BIT];
         side_chain_mixer_on_o <= mix_sh[MIX_SIDE_BIT];
         adc_channel_mixer_on_o <= mix_sh[MIX_ADC_BIT];
         loopback_mixer_on_o <= mix_sh[MIX_LOOP_BIT];
         distortion_limiter_on_o <= prot_sh[PROT_DIST_BIT];
         droop_protection_on_o <= prot_sh[PROT_DROOP_BIT];
         thermal_foldback_on_o <= prot_sh[PROT_THERM_BIT];
         compressor_on_o <= prot_sh[PROT_COMP_BIT];
         sig_gen1_on_o <= prot_sh[PROT_GEN1_BIT];
         sig_gen2_on_o <= prot_sh[PROT_GEN2_BIT];
         supply_measure_source_o <= prot_sh[PROT_SUPPLY_BIT];
         brownout_shutdown_on_o <= prot_sh[PROT_BROWN_BIT];
      end
   end

   // limiter fields as used by the processing path
   assign power_limiter_on = lim_sh[LIM_ON_BIT];
   assign limiter_attenuation_code = lim_sh[LIM_ATTN_MSB:LIM_ATTN_LSB];
   assign attenuation_source_select = lim_sh[LIM_SRC_BIT];
   assign attenuation_recovery_allow = lim_sh[LIM_RECOV_BIT];

   // limiter steps one cycle after the boundary, on the fresh shadow
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_d_r <= 1'b0;
      end else begin
         tick_d_r <= sample_tick_i;
      end
   end

   always_comb begin
      if (attenuation_source_select) begin
         target_code = gpa_atten_code_i;
      end else if (pin_level) begin
         target_code = limiter_attenuation_code;
      end else begin
         target_code = ATTN_NONE;
      end
   end

   assign recover_ok = !pin_level || gpa_recovered_i;

   always_comb begin
      applied_nxt = applied_atten_code_o;
      if (!power_limiter_on) begin
         applied_nxt = ATTN_NONE;
      end else if (target_code > applied_atten_code_o) begin
         applied_nxt = target_code;
      end else if (target_code < applied_atten_code_o) begin
         if (attenuation_recovery_allow && recover_ok) begin
            applied_nxt = target_code;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         applied_atten_code_o <= ATTN_NONE;
         applied_atten_db_o <= 6'h00;
         applied_atten_on_o <= 1'b0;
      end else if (tick_d_r) begin
         applied_atten_code_o <= applied_nxt;
         applied_atten_db_o <= {3'h0, applied_nxt} * ATTN_STEP_DB;
         applied_atten_on_o <= power_limiter_on;
      end
   end

   // checks
   property p_lim_rsvd;
      @(posedge ref_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == REG_LIM_ADDR |=> reg_rdata_o[1:0] == 2'h0;
   endproperty
   a_lim_rsvd: assert property (p_lim_rsvd) else $error("limiter reserved bit set");

   property p_mix_rsvd;
      @(posedge ref_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == REG_MIX_ADDR |=> reg_rdata_o[3:0] == 4'h0;
   endproperty
   a_mix_rsvd: assert property (p_mix_rsvd) else $error("mixer reserved bits nonzero");

   property p_prot_wr;
      @(posedge ref_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == REG_PROT_ADDR ##1 reg_rd_i && !reg_wr_i
         && reg_addr_i == REG_PROT_ADDR |=> reg_rdata_o == $past(reg_wdata_i, 2);
   endproperty
   a_prot_wr: assert property (p_prot_wr) else $error("protection write not read back");

   property p_unmapped;
      @(posedge ref_clk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i != REG_LIM_ADDR && reg_addr_i != REG_MIX_ADDR
         && reg_addr_i != REG_PROT_ADDR |=> reg_rdata_o == RDATA_NONE;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_mix_apply;
      @(posedge ref_clk_i) disable iff (rst_i)
      sample_tick_i |=> ##1 playback_serial_mixer_on_o == $past(mix_r[MIX_SERIAL_BIT], 2);
   endproperty
   a_mix_apply: assert property (p_mix_apply) else $error("mixer enable not applied");

   property p_hold_between;
      @(posedge ref_clk_i) disable iff (rst_i)
      !sample_tick_i ##1 !sample_tick_i |=> $stable(brownout_shutdown_on_o)
         && $stable(droop_protection_on_o) && $stable(supply_measure_source_o);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("enable moved early");

   property p_no_recover;
      @(posedge ref_clk_i) disable iff (rst_i)
      tick_d_r && power_limiter_on && !attenuation_recovery_allow
         |=> applied_atten_code_o >= $past(applied_atten_code_o);
   endproperty
   a_no_recover: assert property (p_no_recover) else $error("attenuation lowered");

   property p_recover;
      @(posedge ref_clk_i) disable iff (rst_i)
      tick_d_r && power_limiter_on && attenuation_recovery_allow && !pin_level
         && !attenuation_source_select |=> applied_atten_code_o == ATTN_NONE;
   endproperty
   a_recover: assert property (p_recover) else $error("attenuation not recovered");

   property p_off;
      @(posedge ref_clk_i) disable iff (rst_i)
      tick_d_r && !power_limiter_on |=> applied_atten_code_o == ATTN_NONE && !applied_atten_on_o;
   endproperty
   a_off: assert property (p_off) else $error("limiter off but attenuating");

   property p_db_step;
      @(posedge ref_clk_i) disable iff (rst_i)
      applied_atten_db_o == {3'h0, applied_atten_code_o} * ATTN_STEP_DB;
   endproperty
   a_db_step: assert property (p_db_step) else $error("dB value not six per code");

   property p_lut_src;
      @(posedge ref_clk_i) disable iff (rst_i)
      tick_d_r && power_limiter_on && attenuation_source_select
         && gpa_atten_code_i > applied_atten_code_o
         |=> applied_atten_code_o == $past(gpa_atten_code_i);
   endproperty
   a_lut_src: assert property (p_lut_src) else $error("lookup attenuation not applied");

   property p_gen_apply;
      @(posedge ref_clk_i) disable iff (rst_i)
      sample_tick_i |=> ##1 sig_gen2_on_o == $past(prot_r[PROT_GEN2_BIT], 2)
         && compressor_on_o == $past(prot_r[PROT_COMP_BIT], 2);
   endproperty
   a_gen_apply: assert property (p_gen_apply) else $error("generator not applied");

   property p_supply_apply;
      @(posedge ref_clk_i) disable iff (rst_i)
      sample_tick_i |=> ##1 supply_measure_source_o == $past(prot_r[PROT_SUPPLY_BIT], 2)
         && brownout_shutdown_on_o == $past(prot_r[PROT_BROWN_BIT], 2);
   endproperty
   a_supply_apply: assert property (p_supply_apply) else $error("supply select late");
endmodule
`default_nettype wire

// ### verification/tb_audio_dsp_protection_config.sv
// self-checking bench for the playback protection configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_audio_dsp_protection_config;
   import apc_pkg::*;
   logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, sample_tick_i, limit_pin_i, gpa_recovered_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [2:0] gpa_atten_code_i, applied_atten_code_o;
   logic [5:0] applied_atten_db_o;
   logic applied_atten_on_o;
   logic [3:0] mix_o;
   logic [7:0] prot_o;
   logic [7:0] m_lim, m_mix, m_prot, s_lim, s_mix, s_prot;
   logic [2:0] e_code;
   int miscompares, n_checks;

   apc_prot_cfg uut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .sample_tick_i(sample_tick_i), .limit_pin_i(limit_pin_i),
      .gpa_atten_code_i(gpa_atten_code_i), .gpa_recovered_i(gpa_recovered_i),
      .applied_atten_on_o(applied_atten_on_o), .applied_atten_code_o(applied_atten_code_o),
      .applied_atten_db_o(applied_atten_db_o),
      .playback_serial_mixer_on_o(mix_o[3]), .side_chain_mixer_on_o(mix_o[2]),
      .adc_channel_mixer_on_o(mix_o[1]), .loopback_mixer_on_o(mix_o[0]),
      .distortion_limiter_on_o(prot_o[7]), .droop_protection_on_o(prot_o[6]),
      .thermal_foldback_on_o(prot_o[5]), .compressor_on_o(prot_o[4]),
      .sig_gen1_on_o(prot_o[3]), .sig_gen2_on_o(prot_o[2]),
      .supply_measure_source_o(prot_o[1]), .brownout_shutdown_on_o(prot_o[0])
   );

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // expected applied attenuation after one boundary
   function automatic logic [2:0] lim_next(input logic [7:0] p, input logic [2:0] cur,
                                           input logic pin, input logic [2:0] gpa,
                                           input logic rec);
      logic [2:0] tgt;
      tgt = p[3] ? gpa : (pin ? p[6:4] : ATTN_NONE);
      if (!p[7]) return ATTN_NONE;
      if (tgt > cur) return tgt;
      if (tgt < cur && p[2] && (!pin || rec)) return tgt;
      return cur;
   endfunction

   function automatic logic [7:0] rd_model(input logic [7:0] a);
      case (a)
         REG_LIM_ADDR: return m_lim;
         REG_MIX_ADDR: return m_mix;
         REG_PROT_ADDR: return m_prot;
         default: return RDATA_NONE;
      endcase
   endfunction

   // legal write data: reserved bits keep their reset value
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         REG_LIM_ADDR: return LIM_WMASK;
         REG_MIX_ADDR: return MIX_WMASK;
         default: return 8'hff;
      endcase
   endfunction

   task automatic model_reset();
      m_lim = REG_LIM_RST;
      m_mix = REG_MIX_RST;
      m_prot = REG_PROT_RST;
      s_lim = REG_LIM_RST;
      s_mix = REG_MIX_RST;
      s_prot = REG_PROT_RST;
      e_code = ATTN_NONE;
   endtask

   task automatic outs();
      // processing outputs follow shadow copy
      chk({4'h0, mix_o, prot_o}, {4'h0, s_mix[7:4], s_prot});
      // limiter result and its magnitude
      chk({6'h00, applied_atten_on_o, applied_atten_code_o, applied_atten_db_o},
          {6'h00, s_lim[LIM_ON_BIT], e_code, 6'(e_code) * ATTN_STEP_DB});
   endtask

   // one access cycle: optional write, read and boundary strobe together
   task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w,
                      input logic r, input logic t);
      logic [7:0] exp_rd;
      d = d & wmask(a);
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = w;
      reg_rd_i = r;
      sample_tick_i = t;
      exp_rd = rd_model(a);
      if (t) begin
         s_lim = m_lim;
         s_mix = m_mix;
         s_prot = m_prot;
         e_code = lim_next(s_lim, e_code, limit_pin_i, gpa_atten_code_i, gpa_recovered_i);
      end
      if (w) begin
         case (a)
            REG_LIM_ADDR: m_lim = d & LIM_WMASK;
            REG_MIX_ADDR: m_mix = d & MIX_WMASK;
            REG_PROT_ADDR: m_prot = d & PROT_WMASK;
            default: ;
         endcase
      end
      @(negedge ref_clk_i);
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      sample_tick_i = 1'b0;
      if (r) chk({8'h00, reg_rdata_o}, {8'h00, exp_rd});
      if (t) begin
         repeat (2) @(negedge ref_clk_i);
         outs();
      end
   endtask

   task automatic set_pin(input logic pin, input logic [2:0] gpa, input logic rec);
      @(negedge ref_clk_i);
      limit_pin_i = pin;
      gpa_atten_code_i = gpa;
      gpa_recovered_i = rec;
      repeat (8) @(negedge ref_clk_i);
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      miscompares++;
      final_report();
   end

   initial begin
      rst_i = 1'b1;
      {reg_wr_i, reg_rd_i, sample_tick_i, limit_pin_i, gpa_recovered_i} = 5'h00;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      gpa_atten_code_i = 3'h0;
      void'($urandom(32'h7a1b));
      model_reset();
      repeat (5) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_i = 1'b0;
      outs();
      for (int i = 0; i < 5; i++) cyc(8'h2a + 8'(i), 8'h00, 1'b0, 1'b1, 1'b0);
      // all-ones then random data across mapped and unmapped places
      for (int i = 0; i < 20; i++) begin
         cyc(8'h2a + 8'(i % 5), (i < 5) ? 8'hff : 8'($urandom), 1'b1, 1'b0, 1'b0);
         cyc(8'h2a + 8'(i % 5), 8'h00, 1'b0, 1'b1, 1'b0);
      end
      // read in the write cycle returns the old value
      cyc(REG_PROT_ADDR, 8'h5a, 1'b1, 1'b1, 1'b0);
      // a write alone does not reach the path
      cyc(REG_MIX_ADDR, 8'ha0, 1'b1, 1'b0, 1'b0);
      repeat (3) @(negedge ref_clk_i);
      outs();
      cyc(REG_MIX_ADDR, 8'h00, 1'b0, 1'b0, 1'b1);
      // write together with the boundary waits one more boundary
      cyc(REG_MIX_ADDR, 8'h50, 1'b1, 1'b0, 1'b1);
      cyc(REG_MIX_ADDR, 8'h00, 1'b0, 1'b0, 1'b1);
      // walking one over every enable bit
      for (int b = 0; b < 8; b++) begin
         cyc(REG_MIX_ADDR, 8'h10 << (b % 4), 1'b1, 1'b0, 1'b0);
         cyc(REG_PROT_ADDR, 8'h01 << b, 1'b1, 1'b0, 1'b1);
      end
      // rising codes from the field with pin high
      set_pin(1'b1, 3'h0, 1'b0);
      for (int c = 0; c < 8; c++) begin
         cyc(REG_LIM_ADDR, {1'b1, 3'(c), 4'h0}, 1'b1, 1'b0, 1'b1);
      end
      // no recovery allowed: lower target holds the level
      cyc(REG_LIM_ADDR, 8'h90, 1'b1, 1'b0, 1'b1);
      set_pin(1'b0, 3'h0, 1'b1);
      cyc(REG_LIM_ADDR, 8'h00, 1'b0, 1'b0, 1'b1);
      // recovery allowed with pin low drops the level
      cyc(REG_LIM_ADDR, 8'h94, 1'b1, 1'b0, 1'b1);
      cyc(REG_LIM_ADDR, 8'h00, 1'b0, 1'b0, 1'b1);
      // lookup source follows the analog code, then switch off
      set_pin(1'b1, 3'h5, 1'b0);
      cyc(REG_LIM_ADDR, 8'h88, 1'b1, 1'b0, 1'b1);
      cyc(REG_LIM_ADDR, 8'h08, 1'b1, 1'b0, 1'b1);
      cyc(REG_LIM_ADDR, 8'h00, 1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 40; i++) begin
         set_pin(1'($urandom), 3'($urandom), 1'($urandom));
         cyc(REG_LIM_ADDR, 8'($urandom), 1'b1, 1'b0, 1'b1);
         cyc(REG_PROT_ADDR, 8'($urandom), 1'b1, 1'b0, 1'b1);
      end
      // second reset in mid-run
      @(negedge ref_clk_i);
      rst_i = 1'b1;
      model_reset();
      repeat (2) @(negedge ref_clk_i);
      outs();
      rst_i = 1'b0;
      cyc(REG_LIM_ADDR, 8'h00, 1'b0, 1'b1, 1'b0);
      cyc(REG_PROT_ADDR, 8'h00, 1'b0, 1'b1, 1'b1);
      final_report();
   end
endmodule
`default_nettype wire
